// ### hdl/sleep_power_down_control.sv
// Operation
// - Sleep entered only by sleep instruction.
// - Sleep entry clears watchdog; may keep counting.
// - Completed entry clears power_down, sets timeout.
// - Processor clock stopped; low-freq oscillator runs.
// - Timer1 runs in sleep on capable clocks.
// - Converter runs in sleep on dedicated oscillator.
// - I/O ports hold drive state during sleep.
// - Non-watchdog resets behave same in sleep.
// - Hard resets reset; other wakes continue.
// - Next instruction prefetched during sleep instruction.
// - Enabled interrupt wakes regardless of global enable.
// - After wake, branch to handler only if global.
// - Watchdog cleared on every wake-up.
// - Pending interrupt makes sleep a no-operation.
// - Interrupt during sleep: complete then wake immediately.
// - Select bit puts regulator low-power in sleep.
// - Low-power regulator wake adds settle delay.
// - Incompatible peripheral keeps regulator normal.
// - High-freq oscillator may run for waveform unit.
// - Unregulated variant: no low-power select, no delay.
// - Select bit zero normal, one low-power.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sleep_power_down_control
	import sleep_pkg::*;
#(
	parameter bit              UNREGULATED = 1'b0,
	parameter int              SETTLE_CYC  = REG_SETTLE_CYC
) (
	input  wire logic          clock,
	input  wire logic          srst,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [7:0]    reg_rdata,
	input  wire logic          sleep_exec,
	input  wire logic          clrwdt_exec,
	input  wire logic          irq_pending,
	input  wire logic          global_irq_enable,
	input  wire logic          wdt_enabled,
	input  wire logic          wdt_tick,
	input  wire logic          master_clear_pin_reset,
	input  wire logic          brownout_reset,
	input  wire logic          power_on_reset,
	input  wire logic          lp_incompatible_periph,
	input  wire logic          cwu_needs_hfosc,
	input  wire logic          tmr1_sleep_clk_sel,
	input  wire logic          adc_dedicated_osc_sel,
	output logic               cpu_clk_en,
	output logic               low_freq_osc_en,
	output logic               high_freq_osc_en,
	output logic               tmr1_run,
	output logic               adc_run,
	output logic               io_hold,
	output logic               prefetch_next,
	output logic               device_reset,
	output logic               irq_vector,
	output logic               wdt_timeout,
	output logic               regulator_low_power,
	output logic               power_down_flag,
	output logic               timeout_flag
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	power_state_t      state_q, state_d;
	logic [7:0]        reg_ctrl_q;
	logic              pd_q, to_q;
	logic              wdt_slp_q;
	logic [WDT_W-1:0]  wdt_q, wdt_d;
	logic [15:0]       settle_q, settle_d;
	logic [7:0]        rdata_q;
	logic              hard_rst;

	// Decoded events.
	wire logic sleep_nop   = sleep_exec && irq_pending && state_q == ST_AWAKE;
	wire logic sleep_go    = sleep_exec && !irq_pending && state_q == ST_AWAKE;
	wire logic lp_sel      = !UNREGULATED && reg_ctrl_q[POS_REGPM];
	wire logic lp_active   = lp_sel && !lp_incompatible_periph;
	wire logic wdt_counts  = wdt_enabled && (state_q == ST_AWAKE || wdt_slp_q);
	wire logic wdt_expire  = wdt_counts && wdt_tick && (&wdt_q);
	wire logic asleep_now  = state_q == ST_ASLEEP;
	wire logic wake_soft   = asleep_now && (irq_pending || wdt_expire);
	wire logic wake_done   = (wake_soft && !lp_active)
	                       || (state_q == ST_SETTLE && settle_q == 16'h0000);

	assign hard_rst = srst || master_clear_pin_reset || brownout_reset
	                || power_on_reset;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Next state: enter only on the sleep instruction, wake on events.
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		unique case (state_q)
			ST_AWAKE: begin
				if (sleep_go) begin
					state_d = ST_ASLEEP;
				end
			end
			ST_ASLEEP: begin
				if (wake_soft && lp_active) begin
					state_d  = ST_SETTLE;
					settle_d = 16'(SETTLE_CYC - 1);
				end else if (wake_soft) begin
					state_d = ST_AWAKE;
				end
			end
			ST_SETTLE: begin
				if (settle_q == 16'h0000) begin
					state_d = ST_AWAKE;
				end else begin
					settle_d = settle_q - 16'h0001;
				end
			end
			default: state_d = ST_AWAKE;
		endcase
	end

	// Watchdog count: cleared on entry, wake, and clear instruction.
	always_comb begin
		wdt_d = wdt_q;
		if (sleep_go || wake_soft || clrwdt_exec && !asleep_now) begin
			wdt_d = '0;
		end else if (wdt_counts && wdt_tick) begin
			wdt_d = wdt_q + 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			state_q  <= ST_AWAKE;
			settle_q <= 16'h0000;
			wdt_q    <= '0;
		end else begin
			state_q  <= state_d;
			settle_q <= settle_d;
			wdt_q    <= wdt_d;
		end
	end

	// Status flags: power_down cleared and timeout set on completed entry, untouched by a no-op sleep.
	always_ff @(posedge clock) begin
		if (hard_rst) begin
			pd_q <= PD_RST;
			to_q <= TO_RST;
		end else if (sleep_go) begin
			pd_q <= 1'b0;
			to_q <= 1'b1;
		end else if (clrwdt_exec && !asleep_now) begin
			pd_q <= 1'b1;
			to_q <= 1'b1;
		end else if (wdt_expire && !asleep_now) begin
			to_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	// Writes: reserved bit forced set, select bit only on regulated parts.
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_ctrl_q <= REG_CTRL_RST;
			wdt_slp_q  <= WDT_SLP_RST;
		end else if (reg_wr && reg_addr == OFS_REG_CTRL) begin
			reg_ctrl_q[POS_REGPM] <= reg_wdata[POS_REGPM]
			                         && !UNREGULATED;
			reg_ctrl_q[POS_RESERVED] <= 1'b1;
		end else if (reg_wr && reg_addr == OFS_WDT_CTRL) begin
			wdt_slp_q <= reg_wdata[POS_WDT_SLP];
		end
	end

	// Read mux, answered one cycle after the strobe.
	wire logic [7:0] rd_mux =
		(reg_addr == OFS_REG_CTRL)  ? reg_ctrl_q :
		(reg_addr == OFS_STATUS)    ? {3'h0, to_q, pd_q, 1'b0,
		                               state_q == ST_SETTLE, asleep_now} :
		(reg_addr == OFS_WDT_CTRL)  ? {7'h00, wdt_slp_q} :
		(reg_addr == OFS_WDT_COUNT) ? wdt_q[7:0] : 8'h00;

	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata        = rdata_q;
	assign power_down_flag  = pd_q;
	assign timeout_flag     = to_q;
	assign cpu_clk_en       = state_q == ST_AWAKE;
	assign low_freq_osc_en  = 1'b1;
	assign high_freq_osc_en = !asleep_now || cwu_needs_hfosc;
	assign tmr1_run         = !asleep_now || tmr1_sleep_clk_sel;
	assign adc_run          = !asleep_now || adc_dedicated_osc_sel;
	assign io_hold          = state_q != ST_AWAKE;
	assign prefetch_next    = sleep_exec && state_q == ST_AWAKE;
	assign device_reset     = master_clear_pin_reset || brownout_reset
	                        || power_on_reset;
	assign irq_vector       = wake_done && irq_pending
	                        && global_irq_enable;
	assign wdt_timeout      = wdt_expire && !asleep_now;
	assign regulator_low_power = asleep_now && lp_active;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Every check below runs on the system clock and is masked while any
	// reset source is active; the hard-reset and register checks mask only srst.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (hard_rst);

	// Steps of a sleep: the instruction on an awake core, a parked core,
	// an interrupt that finds it parked, and the wake that follows.
	sequence s_sleep_nop;
		sleep_nop;
	endsequence

	sequence s_sleep_go;
		sleep_go;
	endsequence

	sequence s_irq_in_sleep;
		asleep_now && irq_pending;
	endsequence

	sequence s_fast_wake;
		wake_soft && !lp_active;
	endsequence

	sequence s_slow_wake;
		wake_soft && lp_active;
	endsequence

	// Entry and the status it leaves behind.
	AST_ENTRY_ONLY_ON_SLEEP: assert property (
		$rose(asleep_now) |-> $past(sleep_exec))
		else $error("Sleep entered without sleep instruction.");
	AST_WDT_CLR_ENTRY: assert property (
		s_sleep_go |=> wdt_q == '0)
		else $error("Watchdog not cleared on sleep entry.");
	AST_FLAGS_ENTRY: assert property (
		s_sleep_go |=> !power_down_flag && timeout_flag && asleep_now)
		else $error("Flags wrong after sleep entry.");
	AST_PREFETCH: assert property (
		sleep_exec && state_q == ST_AWAKE |-> prefetch_next)
		else $error("Next instruction not prefetched.");

	// What keeps running while the core is parked.
	AST_CPU_CLK_OFF: assert property (
		asleep_now |-> !cpu_clk_en && low_freq_osc_en)
		else $error("Processor clock running in sleep.");
	AST_TMR1_RUN: assert property (
		asleep_now && tmr1_sleep_clk_sel |-> tmr1_run)
		else $error("Timer1 stopped in sleep on a capable clock.");
	AST_ADC_RUN: assert property (
		asleep_now && adc_dedicated_osc_sel |-> adc_run)
		else $error("Converter stopped in sleep on its own oscillator.");
	AST_IO_HOLD: assert property (
		asleep_now |-> io_hold)
		else $error("I/O not held in sleep.");
	AST_HFOSC: assert property (
		asleep_now && !cwu_needs_hfosc |-> !high_freq_osc_en)
		else $error("High-frequency oscillator left running in sleep.");

	// Hard resets act at once, asleep or awake, and end any sleep.
	AST_HARD_RST: assert property (disable iff (srst)
		(master_clear_pin_reset || brownout_reset || power_on_reset)
		|-> device_reset ##1 (state_q == ST_AWAKE && power_down_flag
		&& timeout_flag))
		else $error("Hard reset did not reset the sequencer.");

	// Wake-up by an enabled interrupt, with or without the global enable.
	AST_WAKE_CLR: assert property (
		wake_soft |=> wdt_q == '0 && !asleep_now)
		else $error("Watchdog not cleared on wake.");
	AST_WAKE_IRQ: assert property (
		s_irq_in_sleep |=> !asleep_now)
		else $error("Enabled interrupt did not wake the device.");
	AST_WAKE_FLAGS: assert property (
		s_irq_in_sleep |=> !power_down_flag && timeout_flag)
		else $error("Flags changed by an interrupt wake.");
	AST_VECTOR_GATED: assert property (
		irq_vector |-> global_irq_enable && wake_done)
		else $error("Handler entered without global enable.");
	AST_VECTOR_TAKEN: assert property (
		wake_done && irq_pending && global_irq_enable |-> irq_vector)
		else $error("Handler not entered after wake.");

	// A pending interrupt turns the instruction into a no-operation, so
	// neither the flags nor the watchdog may move because of it.
	AST_NOP_SLEEP: assert property (
		s_sleep_nop |=> $stable(power_down_flag) && $stable(timeout_flag)
		&& !asleep_now)
		else $error("No-op sleep changed state.");
	AST_NOP_WDT: assert property (
		s_sleep_nop && !clrwdt_exec && !(wdt_counts && wdt_tick)
		|=> $stable(wdt_q))
		else $error("No-op sleep cleared the watchdog.");

	// Regulator power and the settle delay it costs on the way out.
	// An incompatible peripheral overrides the select bit.
	AST_LP_SEL: assert property (
		asleep_now && reg_ctrl_q[POS_REGPM] && !lp_incompatible_periph
		&& !UNREGULATED |-> regulator_low_power)
		else $error("Low-power regulator sleep not applied.");
	AST_LP_ONLY_ASLEEP: assert property (
		regulator_low_power |-> asleep_now && reg_ctrl_q[POS_REGPM])
		else $error("Regulator low-power outside sleep.");
	AST_LP_REG: assert property (
		lp_incompatible_periph |-> !regulator_low_power)
		else $error("Regulator low-power with incompatible peripheral.");
	AST_FAST_WAKE: assert property (
		s_fast_wake |=> cpu_clk_en)
		else $error("Normal regulator wake was not immediate.");
	AST_SETTLE: assert property (
		s_slow_wake |=> (state_q == ST_SETTLE) [*2])
		else $error("Settle delay skipped.");
	AST_UNREG: assert property (disable iff (srst)
		UNREGULATED |-> !reg_ctrl_q[POS_REGPM]
		&& !regulator_low_power)
		else $error("Unregulated part offered low-power sleep.");
	AST_RESERVED: assert property (disable iff (srst)
		reg_ctrl_q[POS_RESERVED])
		else $error("Reserved bit cleared.");

endmodule

`default_nettype wire

// ### hdl/sleep_pkg.sv
package sleep_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_REG_CTRL   = 4'h0; // regulator_sleep_control
	localparam logic [3:0] OFS_STATUS     = 4'h1; // flags and state
	localparam logic [3:0] OFS_WDT_CTRL   = 4'h2; // watchdog sleep enable
	localparam logic [3:0] OFS_WDT_COUNT  = 4'h3; // watchdog count low byte

	localparam int POS_REGPM    = 1;
	localparam int POS_RESERVED = 0;
	localparam int POS_PD       = 3;
	localparam int POS_TO       = 4;
	localparam int POS_ASLEEP   = 0;
	localparam int POS_WAKING   = 1;
	localparam int POS_WDT_SLP  = 0;

	localparam logic [7:0] REG_CTRL_RST   = 8'h01;
	localparam logic       PD_RST         = 1'b1;
	localparam logic       TO_RST         = 1'b1;
	localparam logic       WDT_SLP_RST    = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int REG_SETTLE_NS    = 2000;
	localparam int REG_SETTLE_CYC   = (REG_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int WDT_W            = 16;

	typedef enum logic [1:0] {
		ST_AWAKE  = 2'b00,
		ST_ASLEEP = 2'b01,
		ST_SETTLE = 2'b11
	} power_state_t;

	typedef struct packed {
		logic addr_unused;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic master_clear_pin;
		logic bor;
		logic por;
	} reset_src_t;

endpackage

// ### tb/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Interrupt source: raises an enabled request some cycles into sleep.
// ----------------------------------------------------------------
module irq_source_model (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       cpu_clk_en,
	input  wire logic       arm,
	input  wire logic       pre,
	input  wire logic [2:0] dly,
	output logic            irq_pending
);
	logic [2:0] cnt_q;
	logic       irq_q;

	// The request latches once raised, until the bench disarms it.
	always_ff @(posedge clock) begin
		if (srst || !arm) begin
			cnt_q <= 3'h0;
			irq_q <= 1'b0;
		end else if (!cpu_clk_en) begin
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == dly) irq_q <= 1'b1;
		end
	end

	// A flag already set before sleep is offered through pre.
	assign irq_pending = irq_q | pre;
endmodule
`default_nettype wire

// ### tb/sleep_power_down_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sleep_power_down_control_tb;
	import sleep_pkg::*;
	localparam int SETTLE = 4;
	logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, sleep_exec = 0;
	logic global_irq_enable = 0, lp_incompatible_periph = 0;
	logic cwu_needs_hfosc = 0, tmr1_sleep_clk_sel = 0;
	logic adc_dedicated_osc_sel = 0, arm = 0, pre = 0, rd_seen = 0;
	logic wdt_enabled = 0, wdt_tick = 0, clrwdt_exec = 0, wdt_timeout;
	logic [2:0] hard = 3'h0, dly = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_d;
	logic cpu_clk_en, low_freq_osc_en, high_freq_osc_en, tmr1_run, adc_run;
	logic io_hold, prefetch_next, device_reset, irq_vector, irq_pending;
	logic regulator_low_power, power_down_flag, timeout_flag;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000003D;
	int n_mismatch = 0, check_count = 0, cyc = 0;

	sleep_power_down_control #(.SETTLE_CYC(SETTLE)) uut (
		.clock(clock), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
		.clrwdt_exec(clrwdt_exec), .irq_pending(irq_pending),
		.global_irq_enable(global_irq_enable), .wdt_enabled(wdt_enabled),
		.wdt_tick(wdt_tick), .master_clear_pin_reset(hard[0]), .brownout_reset(hard[1]),
		.power_on_reset(hard[2]),
		.lp_incompatible_periph(lp_incompatible_periph),
		.cwu_needs_hfosc(cwu_needs_hfosc),
		.tmr1_sleep_clk_sel(tmr1_sleep_clk_sel),
		.adc_dedicated_osc_sel(adc_dedicated_osc_sel),
		.cpu_clk_en(cpu_clk_en), .low_freq_osc_en(low_freq_osc_en),
		.high_freq_osc_en(high_freq_osc_en), .tmr1_run(tmr1_run),
		.adc_run(adc_run), .io_hold(io_hold), .prefetch_next(prefetch_next),
		.device_reset(device_reset), .irq_vector(irq_vector),
		.wdt_timeout(wdt_timeout), .regulator_low_power(regulator_low_power),
		.power_down_flag(power_down_flag), .timeout_flag(timeout_flag));

	irq_source_model partner (.clock(clock), .srst(srst),
		.cpu_clk_en(cpu_clk_en), .arm(arm), .pre(pre), .dly(dly),
		.irq_pending(irq_pending));

	// ----------------------------------------------------------------
	// Clock, timeout and helpers.
	// ----------------------------------------------------------------
	always #5 clock = ~clock;

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic stop_test();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t flag %b want %b", $time, g, e);
		end
	endtask

	// Read data stand only in the cycle after the strobe; compare then.
	always @(posedge clock) begin
		if (rd_seen) begin
			exp_d = exp_q.pop_front();
			check_count++;
			if (reg_rdata !== exp_d) begin
				n_mismatch++;
				$display("MISMATCH %0t read %h want %h", $time, reg_rdata, exp_d);
			end
		end
		rd_seen <= reg_rd;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
	endtask

	task automatic slp();
		@(posedge clock);
		sleep_exec <= 1'b1;
		#1 chk(prefetch_next, 1'b1);
		@(posedge clock);
		sleep_exec <= 1'b0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// One full sleep and interrupt wake, checked at the ports.
	// ----------------------------------------------------------------
	task automatic run_sleep(input logic g, input logic lp);
		logic [31:0] r;
		int n;
		r = xs();
		@(posedge clock);
		global_irq_enable <= g;
		tmr1_sleep_clk_sel <= r[0];
		adc_dedicated_osc_sel <= r[1];
		cwu_needs_hfosc <= r[2];
		dly <= r[5:3];
		slp();
		chk(cpu_clk_en, 1'b0);
		chk(low_freq_osc_en, 1'b1);
		chk(io_hold, 1'b1);
		chk(regulator_low_power, lp);
		chk(tmr1_run, r[0]);
		chk(adc_run, r[1]);
		chk(high_freq_osc_en, r[2]);
		rd(OFS_STATUS, 8'h11);
		rd(OFS_WDT_COUNT, 8'h00);
		arm <= 1'b1;
		n = 0;
		while (irq_pending !== 1'b1 && n < 100) begin
			@(posedge clock);
			#1 n++;
		end
		chk(irq_pending, 1'b1);
		chk(irq_vector, g);
		n = 0;
		while (cpu_clk_en !== 1'b1 && n < 50) begin
			@(posedge clock);
			#1 n++;
		end
		chk(n >= (lp ? SETTLE : 1) && n <= (lp ? SETTLE + 2 : 1), 1'b1);
		@(posedge clock);
		arm <= 1'b0;
		rd(OFS_STATUS, 8'h10);
		rd(OFS_WDT_COUNT, 8'h00);
	endtask

	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		rd(OFS_REG_CTRL, REG_CTRL_RST);
		rd(OFS_STATUS, 8'h18);
		rd(OFS_WDT_CTRL, 8'h00);
		wr(4'hF, 8'(xs() >> 24));
		rd(4'hF, 8'h00);
		pre <= 1'b1;
		slp();
		chk(cpu_clk_en, 1'b1);
		rd(OFS_STATUS, 8'h18);
		pre <= 1'b0;
		run_sleep(1'b1, 1'b0);
		wr(OFS_REG_CTRL, 8'h03);
		rd(OFS_REG_CTRL, 8'h03);
		run_sleep(1'b0, 1'b1);
		lp_incompatible_periph <= 1'b1;
		run_sleep(1'b1, 1'b0);
		// Watchdog kept counting in sleep, then cleared by the wake.
		wr(OFS_WDT_CTRL, 8'h01);
		wdt_enabled <= 1'b1;
		wdt_tick <= 1'b1;
		slp();
		rd(OFS_WDT_COUNT, 8'h01);
		wdt_tick <= 1'b0;
		pre <= 1'b1;
		rd(OFS_WDT_COUNT, 8'h00);
		pre <= 1'b0;
		wdt_enabled <= 1'b0;
		rd(OFS_STATUS, 8'h10);
		chk(wdt_timeout, 1'b0);
		clrwdt_exec <= 1'b1;
		@(posedge clock);
		clrwdt_exec <= 1'b0;
		rd(OFS_STATUS, 8'h18);
		for (int i = 0; i < 3; i++) begin
			slp();
			@(posedge clock);
			hard <= 3'(1 << i);
			#1 chk(device_reset, 1'b1);
			@(posedge clock);
			hard <= 3'h0;
			#1 chk(cpu_clk_en, 1'b1);
			rd(OFS_STATUS, 8'h18);
			rd(OFS_REG_CTRL, 8'h03);
		end
		stop_test();
	end
endmodule
`default_nettype wire
